// *** casp_pkg.sv ***
// package of constants and carriers for the channelled serial port
package casp_pkg;

    // ==================================================================
    // control word fields
    localparam int CTL_SELECT_BIT = 0;
    localparam int CTL_DIR_BIT = 1;
    localparam int CTL_CHAN_LSB = 2;
    localparam int CTL_RATE_LSB = 4;
    localparam logic [7:0] CTL_RESET_VALUE = 8'h00;

    // ==================================================================
    // status word fields
    localparam int STS_PARITY_BIT = 0;
    localparam int STS_OVERRUN_BIT = 1;
    localparam int STS_FRAMING_BIT = 2;
    localparam int STS_TXDONE_BIT = 3;
    localparam int STS_TXEMPTY_BIT = 4;
    localparam int STS_RXAVAIL_BIT = 5;
    localparam int STS_READY_BIT = 6;
    localparam logic STS_SPARE_VALUE = 1'b0;

    // ==================================================================
    // timing: reference clock and 16x sampling
    localparam int CLK_HZ = 10_000_000;
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] MID_BIT_COUNT = 4'h7;   // 8 ticks from edge
    localparam logic [3:0] LAST_TICK = 4'hf;
    localparam int BASE_BAUD = 110;
    // half-period of the 16x square wave at the slowest rate, in clk
    localparam int BASE_HALF_CYCLES = CLK_HZ / (BASE_BAUD * OVERSAMPLE * 2);
    localparam logic [11:0] BASE_HALF = 12'(BASE_HALF_CYCLES);

    // ==================================================================
    // frame shape
    localparam logic [3:0] TTY_DATA_BITS = 4'h7;
    localparam logic [3:0] TAPE_DATA_BITS = 4'h8;
    localparam logic [1:0] TTY_CHANNEL = 2'h0;

    // control word carrier
    typedef struct packed {
        logic [3:0] rate;
        logic [1:0] chan;
        logic dir_in;
        logic select;
    } casp_ctl_t;

    // serial engine states
    typedef enum logic [2:0] {
        SER_IDLE, SER_START, SER_DATA, SER_PARITY, SER_STOP
    } casp_ser_t;

endpackage : casp_pkg

// *** casp_port.sv ***
// channelled asynchronous serial port with control/status and data exchange
`timescale 1ns/10ps

// Behaviour
// - separate buffers and shifters for each direction
// - idle transmitter loads buffer into shifter immediately
// - extra interrupt after last character leaves
// - start edge verified low at mid-bit
// - receiver checks parity after last data bit
// - receive interrupt pulses on data-available rise
// - unread character overwritten sets overrun flag
// - frame: start, data, parity, one-plus stops
// - channel zero seven bits, others eight
// - one exchange writes control, returns status
// - select low resets, high enables channel
// - direction bit steers data exchange, driven out
// - channel field picks teleprinter or tape
// - four-bit code programs bit-rate divider
// - status bit zero is parity error
// - status bit one is overrun
// - status bit two is framing error
// - status bit three is character sent
// - status bit four is transmit empty
// - status bit five is receive available
// - error flags cleared by master reset
// - tape channels mask unselected interrupt source
// - bit six ready line, bit seven constant
// - data exchange writes or reads by direction
// - serial output only to selected channel
// - drive square clock at sixteen times rate
// - tape frame twelve bits, teleprinter eleven
module casp_port (
    input wire logic clk,                  // 10 MHz reference
    input wire logic rst,                  // synchronous, active high
    input wire logic control_status_exchange, // one-cycle strobe
    input wire logic data_exchange,        // one-cycle strobe
    input wire logic [7:0] acc_in,         // accumulator value offered
    output logic [7:0] acc_out,            // value returned to accumulator
    input wire logic [3:0] ready_in,       // ready line of each device
    input wire logic [3:0] serial_in,      // serial data from each device
    output logic [3:0] serial_out,         // serial data to each device
    output logic [3:0] channel_enable,     // per-device enable
    output logic dir_in_out,               // direction to all devices
    output logic clock_16x,                // square wave at 16x bit rate
    output logic interrupt                 // one-cycle interrupt request
);
    import casp_pkg::*;

    // ==================================================================
    // control word and derived settings
    casp_ctl_t ctl;          // last control word written
    logic core_rst;          // master reset of the serial core
    logic [3:0] data_bits;   // active word length
    logic [11:0] half_limit; // divider half-period in clk cycles
    logic [11:0] div_cnt;    // divider counter
    logic tick;              // one pulse per 16x clock period

    assign core_rst = rst | ~ctl.select;
    // shared word-length setting for both directions
    assign data_bits = (ctl.chan == TTY_CHANNEL) ? TTY_DATA_BITS
                                                 : TAPE_DATA_BITS;
    // binary divider: code n halves the period n times; codes beyond the
    // 1760 baud step saturate so the range stays 110..1760 baud
    assign half_limit = BASE_HALF >> ((ctl.rate > 4'h4)
        ? 4'h4 : ctl.rate);

    // control word latched on every control/status exchange
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl <= casp_ctl_t'(CTL_RESET_VALUE);
        end else if (control_status_exchange) begin
            ctl <= casp_ctl_t'(acc_in);
        end
    end

    // ==================================================================
    // rate divider: square wave and tick for the serial engines
    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt <= 12'h0000;
            clock_16x <= 1'b0;
        end else if (div_cnt + 12'h0001 >= half_limit) begin
            div_cnt <= 12'h0000;
            clock_16x <= ~clock_16x;
        end else begin
            div_cnt <= div_cnt + 12'h0001;
        end
    end
    // one tick per full square-wave period, on the falling transition
    assign tick = clock_16x & (div_cnt + 12'h0001 >= half_limit);

    // ==================================================================
    // transmitter
    casp_ser_t tx_state;       // transmit engine state
    logic [7:0] tx_buf;        // transmit buffer
    logic tx_buf_full;         // buffer holds a character
    logic [7:0] tx_shift;      // transmit shift register
    logic tx_par;              // running parity of sent bits
    logic [3:0] tx_sub;        // tick count within a bit
    logic [3:0] tx_bit;        // bit index within the field
    logic tx_line;             // serial level being sent
    logic tx_char_done;        // character finished sending
    logic tx_done_pulse;       // one-cycle tx_char_done
    logic tx_write;            // data exchange in output direction
    logic tx_stop2;            // second stop bit in progress

    assign tx_write = data_exchange & ~ctl.dir_in;

    // transmit buffer: written by software, drained into the shifter
    always_ff @(posedge clk) begin
        if (core_rst) begin
            tx_buf <= 8'h00;
            tx_buf_full <= 1'b0;
        end else if (tx_write) begin
            tx_buf <= acc_in;
            tx_buf_full <= 1'b1;
        end else if (tx_state == SER_IDLE && tx_buf_full) begin
            tx_buf_full <= 1'b0;
        end
    end

    // transmit engine: start, data lsb first, parity, two stop bits
    always_ff @(posedge clk) begin
        if (core_rst) begin
            tx_state <= SER_IDLE;
            tx_shift <= 8'h00;
            tx_par <= 1'b0;
            tx_sub <= 4'h0;
            tx_bit <= 4'h0;
            tx_line <= 1'b1;
            tx_stop2 <= 1'b0;
            tx_done_pulse <= 1'b0;
        end else begin
            tx_done_pulse <= 1'b0;
            unique case (tx_state)
                SER_IDLE: begin
                    tx_line <= 1'b1;
                    if (tx_buf_full) begin
                        // move at once so the buffer frees for the next
                        tx_shift <= tx_buf;
                        tx_par <= 1'b0;
                        tx_sub <= 4'h0;
                        tx_line <= 1'b0;
                        tx_state <= SER_START;
                    end
                end
                SER_START: begin
                    if (tick) begin
                        tx_sub <= tx_sub + 4'h1;
                        if (tx_sub == LAST_TICK) begin
                            tx_line <= tx_shift[0];
                            tx_par <= tx_shift[0];
                            tx_bit <= 4'h1;
                            tx_state <= SER_DATA;
                        end
                    end
                end
                SER_DATA: begin
                    if (tick) begin
                        tx_sub <= tx_sub + 4'h1;
                        if (tx_sub == LAST_TICK) begin
                            tx_shift <= {1'b0, tx_shift[7:1]};
                            if (tx_bit == data_bits) begin
                                // transmitter always generates parity
                                tx_line <= tx_par;
                                tx_state <= SER_PARITY;
                            end else begin
                                tx_line <= tx_shift[1];
                                tx_par <= tx_par ^ tx_shift[1];
                                tx_bit <= tx_bit + 4'h1;
                            end
                        end
                    end
                end
                SER_PARITY: begin
                    if (tick) begin
                        tx_sub <= tx_sub + 4'h1;
                        if (tx_sub == LAST_TICK) begin
                            tx_line <= 1'b1;
                            tx_stop2 <= 1'b0;
                            tx_state <= SER_STOP;
                        end
                    end
                end
                SER_STOP: begin
                    // two stops: 12-bit tape, 11-bit teleprinter frames
                    if (tick) begin
                        tx_sub <= tx_sub + 4'h1;
                        if (tx_sub == LAST_TICK) begin
                            tx_stop2 <= 1'b1;
                            if (tx_stop2) begin
                                tx_done_pulse <= 1'b1;
                                tx_state <= SER_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // character-sent flag: set at end of frame, cleared by a new write
    always_ff @(posedge clk) begin
        if (core_rst) begin
            tx_char_done <= 1'b1;
        end else if (tx_done_pulse) begin
            tx_char_done <= 1'b1;
        end else if (tx_write) begin
            tx_char_done <= 1'b0;
        end
    end

    // ==================================================================
    // receiver
    casp_ser_t rx_state;       // receive engine state
    logic [7:0] rx_shift;      // receive shift register
    logic [7:0] rx_buf;        // receive buffer
    logic rx_avail;            // receive data available
    logic rx_avail_d;          // delayed copy for edge detect
    logic rx_par;              // running parity of received data
    logic [3:0] rx_sub;        // tick count within a bit
    logic [3:0] rx_bit;        // data bits taken so far
    logic rx_line;             // selected serial input
    logic rx_line_d;           // previous level for edge detect
    logic rx_read;             // data exchange in input direction
    logic rx_done;             // complete character this cycle
    logic rx_par_bad;          // parity mismatch on this character
    logic err_parity;          // parity error flag
    logic err_overrun;         // overrun flag
    logic err_framing;         // framing error flag

    assign rx_line = serial_in[ctl.chan];
    assign rx_read = data_exchange & ctl.dir_in;

    // receive engine: each bit sampled at its centre
    always_ff @(posedge clk) begin
        if (core_rst) begin
            rx_state <= SER_IDLE;
            rx_shift <= 8'h00;
            rx_par <= 1'b0;
            rx_sub <= 4'h0;
            rx_bit <= 4'h0;
            rx_line_d <= 1'b1;
            rx_done <= 1'b0;
            rx_par_bad <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (tick) begin
                rx_line_d <= rx_line;
            end
            unique case (rx_state)
                SER_IDLE: begin
                    if (tick && rx_line_d && !rx_line) begin
                        rx_sub <= 4'h0;
                        rx_state <= SER_START;
                    end
                end
                SER_START: begin
                    if (tick) begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == MID_BIT_COUNT) begin
                            // a spike that has gone high is noise
                            if (rx_line) begin
                                rx_state <= SER_IDLE;
                            end else begin
                                rx_sub <= 4'h0;
                                rx_bit <= 4'h0;
                                rx_par <= 1'b0;
                                rx_shift <= 8'h00;
                                rx_state <= SER_DATA;
                            end
                        end
                    end
                end
                SER_DATA: begin
                    if (tick) begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == LAST_TICK) begin
                            // shift in at the msb end of the active width
                            rx_shift <= (data_bits == TTY_DATA_BITS)
                                ? {1'b0, rx_line, rx_shift[6:1]}
                                : {rx_line, rx_shift[7:1]};
                            rx_par <= rx_par ^ rx_line;
                            rx_bit <= rx_bit + 4'h1;
                            if (rx_bit + 4'h1 == data_bits) begin
                                rx_state <= SER_PARITY;
                            end
                        end
                    end
                end
                SER_PARITY: begin
                    if (tick) begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == LAST_TICK) begin
                            rx_par_bad <= rx_par ^ rx_line;
                            rx_state <= SER_STOP;
                        end
                    end
                end
                SER_STOP: begin
                    // only one stop is checked; the rest is idle gap
                    if (tick) begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == LAST_TICK) begin
                            rx_done <= 1'b1;
                            rx_state <= SER_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // receive buffer, availability and error flags; set beats clear
    always_ff @(posedge clk) begin
        if (core_rst) begin
            rx_buf <= 8'h00;
            rx_avail <= 1'b0;
            err_parity <= 1'b0;
            err_overrun <= 1'b0;
            err_framing <= 1'b0;
        end else if (rx_done) begin
            rx_buf <= rx_shift;
            rx_avail <= 1'b1;
            err_overrun <= rx_avail & ~rx_read;
            err_parity <= rx_par_bad;
            err_framing <= ~rx_line;
        end else if (rx_read) begin
            rx_avail <= 1'b0;
        end
    end

    // ==================================================================
    // interrupt: rising edges of the two sources, masked on tape
    logic irq_rx;              // receive source pulse
    logic irq_tx;              // transmit source pulse
    logic is_tty;              // teleprinter channel selected

    always_ff @(posedge clk) begin
        if (core_rst) begin
            rx_avail_d <= 1'b0;
        end else begin
            rx_avail_d <= rx_avail;
        end
    end

    assign is_tty = (ctl.chan == TTY_CHANNEL);
    assign irq_rx = rx_avail & ~rx_avail_d;
    // every tx_char_done, the last of a block included
    assign irq_tx = tx_done_pulse;
    assign interrupt = (irq_rx & (is_tty | ctl.dir_in))
                     | (irq_tx & (is_tty | ~ctl.dir_in));

    // ==================================================================
    // status word and accumulator return
    logic [7:0] status;        // current status word

    always_comb begin
        status = 8'h00;
        status[STS_PARITY_BIT] = err_parity;
        status[STS_OVERRUN_BIT] = err_overrun;
        status[STS_FRAMING_BIT] = err_framing;
        status[STS_TXDONE_BIT] = tx_char_done & ~tx_buf_full;
        status[STS_TXEMPTY_BIT] = ~tx_buf_full;
        status[STS_RXAVAIL_BIT] = rx_avail;
        status[STS_READY_BIT] = ready_in[ctl.chan];
        status[7] = STS_SPARE_VALUE;
    end

    // returned value is registered; teleprinter msb reads zero anyway
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_out <= 8'h00;
        end else if (control_status_exchange) begin
            acc_out <= status;
        end else if (rx_read) begin
            acc_out <= rx_buf;
        end
    end

    // ==================================================================
    // device-side outputs
    // unselected lines idle at mark so they never see bits
    always_comb begin
        serial_out = 4'hf;
        channel_enable = 4'h0;
        serial_out[ctl.chan] = tx_line;
        channel_enable[ctl.chan] = ctl.select;
    end
    assign dir_in_out = ctl.dir_in;

endmodule : casp_port

// *** casp_port_assertions.sv ***
// port-level checker for the channelled serial port
`timescale 1ns/10ps
// ====================================================
// checker: control mirror, divider timer, assertions
module casp_port_chk
    import casp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic control_status_exchange,
    input wire logic data_exchange,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] acc_out,
    input wire logic [3:0] ready_in,
    input wire logic [3:0] serial_in,
    input wire logic [3:0] serial_out,
    input wire logic [3:0] channel_enable,
    input wire logic dir_in_out,
    input wire logic clock_16x,
    input wire logic interrupt
);
    casp_ctl_t ctl;     // mirror of the control word
    logic sel_d;        // select as it stood one cycle earlier
    logic clean;        // rate untouched since the last toggle
    logic [11:0] hcnt;  // cycles since the last toggle
    logic rdy;          // ready line of the chosen channel
    logic [11:0] half;  // expected half period; codes above 4 saturate
    assign rdy = ready_in[ctl.chan];
    assign half = BASE_HALF >> ((ctl.rate > 4'h4) ? 4'h4 : ctl.rate);
    // control mirror and its delayed select
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl <= casp_ctl_t'(CTL_RESET_VALUE);
            sel_d <= 1'b0;
        end else begin
            if (control_status_exchange) ctl <= casp_ctl_t'(acc_in);
            sel_d <= ctl.select;
        end
    end
    // a rate change spoils the interval it falls in, so skip that one
    always_ff @(posedge clk) begin
        if (rst || $changed(clock_16x)) hcnt <= 12'h001;
        else hcnt <= hcnt + 12'h001;
        if (rst || control_status_exchange) clean <= 1'b0;
        else if ($changed(clock_16x)) clean <= 1'b1;
    end
    sequence cs_take;
        control_status_exchange;
    endsequence
    sequence quiet;
        !control_status_exchange && !data_exchange;
    endsequence
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    enable_map_a: assert property (
        channel_enable == (ctl.select ? 4'h1 << ctl.chan : 4'h0))
        else $error("channel enable mismatch");
    dir_out_a: assert property (dir_in_out == ctl.dir_in)
        else $error("direction line mismatch");
    quiet_lines_a: assert property (
        (serial_out | (4'h1 << ctl.chan)) == 4'hf)
        else $error("unselected line not idle");
    status_top_a: assert property (
        cs_take |=> acc_out[7:6] == {STS_SPARE_VALUE, $past(rdy)})
        else $error("status ready or spare bit wrong");
    flag_clear_a: assert property (
        cs_take ##0 (!ctl.select && !sel_d) |=> acc_out[2:0] == 3'h0)
        else $error("error flags survive master reset");
    irq_pulse_a: assert property (interrupt |=> !interrupt)
        else $error("interrupt longer than one cycle");
    acc_hold_a: assert property (quiet |=> $stable(acc_out))
        else $error("accumulator answer changed unasked");
    rate_half_a: assert property (
        $changed(clock_16x) && clean && sel_d |-> hcnt == half)
        else $error("16x clock half period wrong");
    reset_out_a: assert property ($fell(rst) |->
        acc_out == 8'h00 && serial_out == 4'hf && channel_enable == 4'h0
        && !interrupt && !clock_16x && !dir_in_out)
        else $error("outputs not at reset values");
endmodule : casp_port_chk
bind casp_port casp_port_chk i_chk (.clk, .rst, .control_status_exchange,
    .data_exchange, .acc_in, .acc_out, .ready_in, .serial_in, .serial_out,
    .channel_enable, .dir_in_out, .clock_16x, .interrupt);

// *** casp_serial_dev.sv ***
// far-side serial device model: sends frames, watches transmit lines
`timescale 1ns/10ps
// ====================================================
// device model; every receive line rests at mark level when idle
module casp_serial_dev (
    input wire logic clk,
    input wire logic [3:0] serial_out,
    output logic [3:0] serial_in,
    output logic [3:0] ready_in
);
    initial begin
        serial_in = 4'hf;   // mark while idle
        ready_in = 4'h2;    // only device one reports ready
    end
    // start, n data lsb first, even parity, one stop
    task automatic send(input int ch, input logic [7:0] d, input int n,
        input int bt, input logic bad_par, input logic bad_stop);
        logic [11:0] fr;
        logic p;
        fr = 12'h000;
        p = bad_par;
        for (int i = 0; i < n; i++) begin
            fr[i + 1] = d[i];
            p = p ^ d[i];
        end
        fr[n + 1] = p;
        fr[n + 2] = !bad_stop;
        for (int i = 0; i < n + 3; i++) begin
            @(negedge clk);
            serial_in[ch] = fr[i];
            // a low stop goes high soon after mid-bit: no false start
            repeat ((bad_stop && i == n + 2) ? bt * 5 / 8 : bt - 1)
                @(negedge clk);
        end
        serial_in[ch] = 1'b1;
    endtask : send
    // low glitch of len cycles; shorter than half a bit it is noise
    task automatic glitch(input int ch, input int len);
        @(negedge clk);
        serial_in[ch] = 1'b0;
        repeat (len) @(negedge clk);
        serial_in[ch] = 1'b1;
    endtask : glitch
    // sample nb bits at mid-bit after the start edge
    task automatic capture(input int ch, input int nb, input int bt,
        output logic [11:0] fr);
        int w;
        fr = 12'h000;
        w = 0;
        while (serial_out[ch] !== 1'b0 && w < 4 * bt) begin
            @(negedge clk);
            w++;
        end
        repeat (bt / 2) @(negedge clk);
        for (int i = 0; i < nb; i++) begin
            fr[i] = serial_out[ch];
            repeat (bt) @(negedge clk);
        end
    endtask : capture
endmodule : casp_serial_dev

// *** tb.sv ***
// self-checking bench for the channelled serial port
`timescale 1ns/10ps
// ====================================================
// bench top: clock, reset, scenarios, verdict
module tb;
    import casp_pkg::*;
    localparam int BIT_T = 32 * (BASE_HALF_CYCLES >> 4); // clk per bit
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cs_x = 1'b0;
    logic dx = 1'b0;
    logic [7:0] acc_in = 8'h00;
    logic [7:0] acc_out;
    logic [3:0] ready_in, serial_in, serial_out, chan_en;
    logic dir_o, clk16, irq;
    int failures = 0;
    int samples_checked = 0;
    int irq_count = 0;
    always #50 clk = ~clk;
    // counted on the falling edge, where the pulse has settled
    always @(negedge clk) if (irq === 1'b1) irq_count++;
    casp_port i_dut (.clk, .rst, .control_status_exchange(cs_x),
        .data_exchange(dx), .acc_in, .acc_out, .ready_in, .serial_in,
        .serial_out, .channel_enable(chan_en), .dir_in_out(dir_o),
        .clock_16x(clk16), .interrupt(irq));
    casp_serial_dev i_dev (.clk, .serial_out, .serial_in, .ready_in);
    task automatic check(input logic [11:0] seen, input logic [11:0] exp,
        input string what);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one strobe of either exchange; answer read a cycle later
    task automatic xchg(input logic data, input logic [7:0] v,
        output logic [7:0] s);
        @(negedge clk);
        if (data) dx = 1'b1;
        else cs_x = 1'b1;
        acc_in = v;
        @(negedge clk);
        dx = 1'b0;
        cs_x = 1'b0;
        s = acc_out;
    endtask : xchg
    task automatic wait16(output int c);
        logic v;
        v = clk16;
        c = 0;
        while (clk16 === v && c < 4000) begin
            @(negedge clk);
            c++;
        end
    endtask : wait16
    task automatic t_status;
        logic [7:0] s;
        xchg(1'b0, 8'h45, s);
        check({s[7:4], s[2:0]}, 7'h08, "idle status");
        xchg(1'b0, 8'h41, s);
        check(s[6], 1'b1, "ready chan1");
        xchg(1'b0, 8'h41, s);
        check(s[6], 1'b0, "ready chan0");
    endtask : t_status
    task automatic t_rates;
        logic [7:0] s;
        int c;
        int codes [6] = '{0, 1, 2, 3, 4, 9};
        foreach (codes[k]) begin
            xchg(1'b0, 8'(codes[k] << 4) | 8'h05, s);
            wait16(c);
            wait16(c);
            check(12'(c), 12'(BASE_HALF_CYCLES >> (codes[k] > 4 ? 4 :
                codes[k])), "half period");
        end
    endtask : t_rates
    // teleprinter: send one character while a bad one arrives
    task automatic t_frames;
        logic [7:0] s;
        logic [11:0] fr;
        xchg(1'b0, 8'h41, s);
        irq_count = 0;
        // a glitch shorter than half a bit must not start a character
        i_dev.glitch(0, BIT_T / 4);
        repeat (BIT_T / 2) @(negedge clk);
        xchg(1'b1, 8'hd5, s);
        fork
            i_dev.capture(0, 11, BIT_T, fr);
            i_dev.send(0, 8'h2b, 7, BIT_T, 1'b1, 1'b1);
        join
        repeat (BIT_T) @(negedge clk);
        check(fr, {3'b011, ^7'h55, 7'h55, 1'b0},
            "tx frame");
        check(12'(irq_count), 12'h002,
            "irq count");
        xchg(1'b0, 8'h43, s);
        check(s[5:0], 6'h3d,
            "rx status");
        xchg(1'b1, 8'h00, s);
        check(s, 8'h2b, "rx data");
        xchg(1'b0, 8'h43, s);
        check(s[5], 1'b0, "rx avail");
        xchg(1'b0, 8'h42, s);
        xchg(1'b0, 8'h42, s);
        check(s[2:0], 3'h0, "flags reset");
    endtask : t_frames
    task automatic print_verdict;
        if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_status();
        t_rates();
        t_frames();
        print_verdict();
    end
    // watchdog: the scenarios need under 9 ms
    initial begin
        #9_500_000;
        failures++;
        print_verdict();
    end
endmodule : tb
